// ---- src/avi_regen_status.sv ----
// Clock regeneration and AVI infoframe status bank with Wishbone slave
//
// Implementation choice: register access over Wishbone.
module avi_regen_status (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone classic slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [9:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Clock regeneration packet from the link decoder
   input  wire logic        acr_valid_i,
   input  wire logic [19:0] acr_cts_i,
   input  wire logic [19:0] acr_n_i,
   // AVI infoframe from the link decoder
   input  wire logic        avi_valid_i,
   input  wire logic [7:0]  avi_version_i,
   input  wire logic [1:0]  avi_colour_format_i,
   input  wire logic        avi_format_present_i,
   input  wire logic [1:0]  avi_bar_info_i,
   input  wire logic [1:0]  avi_scan_info_i,
   input  wire logic [1:0]  avi_colorimetry_i,
   input  wire logic [1:0]  avi_picture_aspect_i,
   input  wire logic [3:0]  avi_active_aspect_i,
   input  wire logic [1:0]  nonuniform_scaling_field_i,
   input  wire logic [6:0]  avi_video_code_i,
   // Frozen flags, also readable in the control register
   output logic             avi_frozen_o,
   output logic             acr_frozen_o
);

   logic [19:0]                             cts_r;
   logic [19:0]                             n_r;
   logic [7:0]                              version_r;
   avi_regen_status_pkg::colour_format_t    colour_format_r;
   logic                                    format_present_r;
   logic [1:0]                              bar_info_r;
   logic [1:0]                              scan_info_r;
   logic [1:0]                              colorimetry_r;
   logic [1:0]                              picture_aspect_r;
   logic [3:0]                              active_aspect_r;
   logic [1:0]                              scaling_r;
   logic [6:0]                              video_code_r;
   logic [avi_regen_status_pkg::CTRL_W-1:0] ctrl_r;
   logic                                    avi_missed_r;
   logic                                    acr_missed_r;
   logic                                    avi_seen_r;
   logic                                    acr_seen_r;
   logic [7:0]                              avi_count_r;
   logic [7:0]                              acr_count_r;
   logic                                    ack_r;
   logic [31:0]                             rd_r;
   logic [31:0]                             rd_nxt;
   logic [7:0]                              idx;
   logic                                    req;
   logic                                    wr_lane0;
   logic                                    avi_take;
   logic                                    acr_take;
   logic                                    ctrl_wr;
   logic                                    stat_wr;

   assign idx      = wb_adr_i[avi_regen_status_pkg::IDX_MSB:avi_regen_status_pkg::IDX_LSB];
   // Only the first edge of a request; ack drops the cycle after
   assign req      = wb_cyc_i && wb_stb_i && !ack_r;
   assign wr_lane0 = req && wb_we_i && wb_sel_i[0];
   // Write strobes for the two writable indices
   assign ctrl_wr  = wr_lane0 && idx == avi_regen_status_pkg::IDX_CTRL;
   assign stat_wr  = wr_lane0 && idx == avi_regen_status_pkg::IDX_STATUS;

   // Freezing lets software read a multi-byte value without tearing
   // valid packet gated by freeze
   assign avi_take = avi_valid_i && !ctrl_r[avi_regen_status_pkg::CTRL_FREEZE_AVI];
   assign acr_take = acr_valid_i && !ctrl_r[avi_regen_status_pkg::CTRL_FREEZE_ACR];

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cts_r <= avi_regen_status_pkg::RST_WORD20;
         n_r   <= avi_regen_status_pkg::RST_WORD20;
      end
      else if (acr_take)
      begin
         cts_r <= acr_cts_i;
         n_r   <= acr_n_i;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         version_r        <= avi_regen_status_pkg::RST_BYTE;
         colour_format_r  <= avi_regen_status_pkg::FMT_RGB;
         format_present_r <= 1'b0;
         bar_info_r       <= 2'h0;
         scan_info_r      <= 2'h0;
         colorimetry_r    <= 2'h0;
         picture_aspect_r <= 2'h0;
         active_aspect_r  <= 4'h0;
         scaling_r        <= 2'h0;
         video_code_r     <= 7'h00;
      end
      else if (avi_take)
      begin
         version_r        <= avi_version_i;
         colour_format_r  <= avi_regen_status_pkg::colour_format_t'(avi_colour_format_i);
         format_present_r <= avi_format_present_i;
         bar_info_r       <= avi_bar_info_i;
         scan_info_r      <= avi_scan_info_i;
         colorimetry_r    <= avi_colorimetry_i;
         picture_aspect_r <= avi_picture_aspect_i;
         active_aspect_r  <= avi_active_aspect_i;
         scaling_r        <= nonuniform_scaling_field_i;
         video_code_r     <= avi_video_code_i;
      end
   end

   // Control register, the only one loaded from the write data
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ctrl_r <= avi_regen_status_pkg::RST_CTRL;
      end
      else if (ctrl_wr)
      begin
         ctrl_r <= wb_dat_i[avi_regen_status_pkg::CTRL_W-1:0];
      end
   end

   // Missed flags: a packet dropped while frozen; set wins over clear
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         avi_missed_r <= 1'b0;
      end
      else if (avi_valid_i && !avi_take)
      begin
         avi_missed_r <= 1'b1;
      end
      else if (stat_wr && wb_dat_i[avi_regen_status_pkg::STAT_AVI_MISSED])
      begin
         avi_missed_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         acr_missed_r <= 1'b0;
      end
      else if (acr_valid_i && !acr_take)
      begin
         acr_missed_r <= 1'b1;
      end
      else if (stat_wr && wb_dat_i[avi_regen_status_pkg::STAT_ACR_MISSED])
      begin
         acr_missed_r <= 1'b0;
      end
   end

   // Seen flags and wrapping packet counters
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         avi_seen_r  <= 1'b0;
         avi_count_r <= avi_regen_status_pkg::RST_BYTE;
      end
      else if (avi_take)
      begin
         avi_seen_r  <= 1'b1;
         avi_count_r <= avi_count_r + 8'h01;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         acr_seen_r  <= 1'b0;
         acr_count_r <= avi_regen_status_pkg::RST_BYTE;
      end
      else if (acr_take)
      begin
         acr_seen_r  <= 1'b1;
         acr_count_r <= acr_count_r + 8'h01;
      end
   end

   // Read decode; unmapped indices read as zero
   // in the status register only the missed flags have a write path, write one to clear
   always_comb
   begin
      rd_nxt = avi_regen_status_pkg::RD_ZERO;
      if (idx == avi_regen_status_pkg::IDX_CTS_HIGH)
      begin
         rd_nxt[7:0] = cts_r[19:12];
      end
      else if (idx == avi_regen_status_pkg::IDX_CTS_MIDDLE)
      begin
         rd_nxt[7:0] = cts_r[11:4];
      end
      else if (idx == avi_regen_status_pkg::IDX_CTS_LOW)
      begin
         rd_nxt[7:0] = {cts_r[3:0], n_r[19:16]};
      end
      else if (idx == avi_regen_status_pkg::IDX_N_MIDDLE)
      begin
         rd_nxt[7:0] = n_r[15:8];
      end
      else if (idx == avi_regen_status_pkg::IDX_N_LOW)
      begin
         rd_nxt[7:0] = n_r[7:0];
      end
      else if (idx == avi_regen_status_pkg::IDX_AVI_VERSION)
      begin
         rd_nxt[7:0] = version_r;
      end
      else if (idx == avi_regen_status_pkg::IDX_AVI_FORMAT)
      begin
         rd_nxt[7:0] = {1'b0, colour_format_r, format_present_r, bar_info_r, scan_info_r};
      end
      else if (idx == avi_regen_status_pkg::IDX_AVI_COLOUR)
      begin
         rd_nxt[7:0] = {colorimetry_r, picture_aspect_r, active_aspect_r};
      end
      else if (idx == avi_regen_status_pkg::IDX_AVI_SCALING)
      begin
         rd_nxt[7:0] = {6'h00, scaling_r};
      end
      else if (idx == avi_regen_status_pkg::IDX_VIDEO_CODE)
      begin
         rd_nxt[7:0] = {1'b0, video_code_r};
      end
      else if (idx == avi_regen_status_pkg::IDX_CTRL)
      begin
         rd_nxt[avi_regen_status_pkg::CTRL_W-1:0] = ctrl_r;
      end
      else if (idx == avi_regen_status_pkg::IDX_STATUS)
      begin
         rd_nxt[avi_regen_status_pkg::STAT_AVI_MISSED] = avi_missed_r;
         rd_nxt[avi_regen_status_pkg::STAT_ACR_MISSED] = acr_missed_r;
         rd_nxt[avi_regen_status_pkg::STAT_AVI_SEEN]   = avi_seen_r;
         rd_nxt[avi_regen_status_pkg::STAT_ACR_SEEN]   = acr_seen_r;
      end
      else if (idx == avi_regen_status_pkg::IDX_COUNTS)
      begin
         rd_nxt[avi_regen_status_pkg::CNT_AVI_LSB +: 8] = avi_count_r;
         rd_nxt[avi_regen_status_pkg::CNT_ACR_LSB +: 8] = acr_count_r;
      end
   end

   // Ack one cycle after the request
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_r <= 1'b0;
      end
      else
      begin
         ack_r <= req;
      end
   end

   // Read data held until the next read is taken
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rd_r <= avi_regen_status_pkg::RD_ZERO;
      end
      else if (req && !wb_we_i)
      begin
         rd_r <= rd_nxt;
      end
   end

   // Frozen flags mirror the control register one cycle late
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         avi_frozen_o <= 1'b0;
      end
      else
      begin
         avi_frozen_o <= ctrl_r[avi_regen_status_pkg::CTRL_FREEZE_AVI];
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         acr_frozen_o <= 1'b0;
      end
      else
      begin
         acr_frozen_o <= ctrl_r[avi_regen_status_pkg::CTRL_FREEZE_ACR];
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = rd_r;

endmodule : avi_regen_status

// ---- src/avi_regen_status_pkg.sv ----
// Constants for the clock regeneration and AVI status register bank
package avi_regen_status_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_CTS_HIGH      = 8'h7b;
   localparam logic [7:0] IDX_CTS_MIDDLE    = 8'h7c;
   localparam logic [7:0] IDX_CTS_LOW       = 8'h7d;
   localparam logic [7:0] IDX_N_HIGH        = 8'h7d;
   localparam logic [7:0] IDX_N_MIDDLE      = 8'h7e;
   localparam logic [7:0] IDX_N_LOW         = 8'h7f;
   localparam logic [7:0] IDX_AVI_VERSION   = 8'h80;
   localparam logic [7:0] IDX_AVI_FORMAT    = 8'h81;
   localparam logic [7:0] IDX_AVI_COLOUR    = 8'h82;
   localparam logic [7:0] IDX_AVI_SCALING   = 8'h83;
   localparam logic [7:0] IDX_VIDEO_CODE    = 8'h84;
   localparam logic [7:0] IDX_CTRL          = 8'hf0;
   localparam logic [7:0] IDX_STATUS        = 8'hf1;
   localparam logic [7:0] IDX_COUNTS        = 8'hf2;

   localparam int ADR_W   = 10;
   localparam int IDX_LSB = 2;
   localparam int IDX_MSB = 9;

   // Control bits
   localparam int CTRL_FREEZE_AVI = 0;
   localparam int CTRL_FREEZE_ACR = 1;
   localparam int CTRL_W          = 2;

   // Status bits
   localparam int STAT_AVI_MISSED = 0;
   localparam int STAT_ACR_MISSED = 1;
   localparam int STAT_AVI_SEEN   = 2;
   localparam int STAT_ACR_SEEN   = 3;

   // Counter byte positions in the counts register
   localparam int CNT_AVI_LSB = 0;
   localparam int CNT_ACR_LSB = 8;

   // Reset values
   localparam logic [19:0]       RST_WORD20 = 20'h00000;
   localparam logic [7:0]        RST_BYTE   = 8'h00;
   localparam logic [CTRL_W-1:0] RST_CTRL   = 2'h0;
   localparam logic [31:0]       RD_ZERO    = 32'h00000000;

   // Colour format codes
   typedef enum logic [1:0] {
      FMT_RGB    = 2'h0,
      FMT_YC_422 = 2'h1,
      FMT_YC_444 = 2'h2
   } colour_format_t;
endpackage : avi_regen_status_pkg

// ---- bench/avi_regen_status_checker.sv ----
// Checker for the status bank handshake and read-back values
module avi_regen_status_checker (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [9:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        acr_valid_i,
   input wire logic [19:0] acr_cts_i,
   input wire logic [19:0] acr_n_i,
   input wire logic        avi_valid_i,
   input wire logic [7:0]  avi_version_i,
   input wire logic [1:0]  avi_colour_format_i,
   input wire logic        avi_format_present_i,
   input wire logic [1:0]  avi_bar_info_i,
   input wire logic [1:0]  avi_scan_info_i,
   input wire logic [1:0]  avi_colorimetry_i,
   input wire logic [1:0]  avi_picture_aspect_i,
   input wire logic [3:0]  avi_active_aspect_i,
   input wire logic [1:0]  nonuniform_scaling_field_i,
   input wire logic [6:0]  avi_video_code_i,
   input wire logic        avi_frozen_o,
   input wire logic        acr_frozen_o
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [19:0] cts_r;
   logic [19:0] n_r;
   logic [31:0] f_r;
   logic [1:0]  frz_r;
   logic [1:0]  frz_d_r;
   logic [7:0]  idx_r;
   logic        rd_r;
   logic [7:0]  exp;
   logic [7:0]  exp_r;
   wire logic   take    = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire logic   rd_ok   = wb_ack_o && rd_r;
   wire logic   data_ok = wb_dat_o == {24'h000000, exp_r};

   // Shadow honours the freeze bits; expected byte is fixed at the taking edge
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cts_r   <= 20'h00000;
         n_r     <= 20'h00000;
         f_r     <= 32'h00000000;
         frz_r   <= 2'h0;
         frz_d_r <= 2'h0;
         rd_r    <= 1'b0;
         exp_r   <= 8'h00;
      end
      else
      begin
         if (acr_valid_i && !frz_r[1])
         begin
            cts_r <= acr_cts_i;
            n_r   <= acr_n_i;
         end
         if (avi_valid_i && !frz_r[0])
         begin
            f_r <= {avi_version_i, avi_colour_format_i, avi_format_present_i, avi_bar_info_i,
               avi_scan_info_i, avi_colorimetry_i, avi_picture_aspect_i, avi_active_aspect_i,
               nonuniform_scaling_field_i, avi_video_code_i};
         end
         if (take && wb_we_i && wb_sel_i[0] && wb_adr_i[9:2] == 8'hf0)
         begin
            frz_r <= wb_dat_i[1:0];
         end
         if (take && !wb_we_i)
         begin
            exp_r <= exp;
         end
         frz_d_r <= frz_r;
         rd_r    <= take && !wb_we_i;
         idx_r   <= wb_adr_i[9:2];
      end
   end

   always_comb
   begin
      case (wb_adr_i[9:2])
         8'h7b:   exp = cts_r[19:12];
         8'h7c:   exp = cts_r[11:4];
         8'h7d:   exp = {cts_r[3:0], n_r[19:16]};
         8'h7e:   exp = n_r[15:8];
         8'h7f:   exp = n_r[7:0];
         8'h80:   exp = f_r[31:24];
         8'h81:   exp = {1'b0, f_r[23:17]};
         8'h82:   exp = f_r[16:9];
         8'h83:   exp = {6'h00, f_r[8:7]};
         8'h84:   exp = {1'b0, f_r[6:0]};
         default: exp = 8'h00;
      endcase
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   a_ack_one_cycle:
      assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
   a_ack_on_request:
      assert property (take |=> wb_ack_o) else $error("request not answered");
   a_no_stray_ack:
      assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("ack without request");
   a_cts_read:
      assert property (rd_ok && idx_r inside {8'h7b, 8'h7c} |-> data_ok) else $error("bad stamp");
   a_shared_nibble:
      assert property (rd_ok && idx_r == 8'h7d |-> data_ok) else $error("bad shared byte");
   a_n_read:
      assert property (rd_ok && idx_r inside {8'h7e, 8'h7f} |-> data_ok) else $error("bad divider");
   a_avi_fields_read:
      assert property (rd_ok && idx_r inside {[8'h80:8'h82]} |-> data_ok) else $error("bad frame");
   a_scaling_code_read:
      assert property (rd_ok && idx_r inside {8'h83, 8'h84} |-> data_ok) else $error("bad code");
   a_frozen_mirror:
      assert property ({acr_frozen_o, avi_frozen_o} == frz_d_r) else $error("bad freeze flags");
endmodule : avi_regen_status_checker

bind avi_regen_status avi_regen_status_checker u_chk (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .avi_frozen_o(avi_frozen_o), .acr_frozen_o(acr_frozen_o),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .acr_valid_i(acr_valid_i),
   .acr_cts_i(acr_cts_i), .acr_n_i(acr_n_i), .avi_valid_i(avi_valid_i),
   .avi_version_i(avi_version_i), .avi_colour_format_i(avi_colour_format_i),
   .avi_format_present_i(avi_format_present_i), .avi_bar_info_i(avi_bar_info_i),
   .avi_scan_info_i(avi_scan_info_i), .avi_colorimetry_i(avi_colorimetry_i),
   .avi_picture_aspect_i(avi_picture_aspect_i), .avi_active_aspect_i(avi_active_aspect_i),
   .nonuniform_scaling_field_i(nonuniform_scaling_field_i),
   .avi_video_code_i(avi_video_code_i));

// ---- bench/link_source_model.sv ----
// Link-side source handing complete packets to the status bank
module link_source_model (
   input  wire logic        clk_i,
   output logic             acr_valid_o,
   output logic [19:0]      acr_cts_o,
   output logic [19:0]      acr_n_o,
   output logic             avi_valid_o,
   output logic [31:0]      avi_fields_o
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      acr_valid_o  = 1'b0;
      acr_cts_o    = 20'h00000;
      acr_n_o      = 20'h00000;
      avi_valid_o  = 1'b0;
      avi_fields_o = 32'h00000000;
   end

   // Fields mean nothing outside the pulse, so they are scrambled after it
   task automatic send_acr(input logic [19:0] cts, input logic [19:0] n);
      @(posedge clk_i);
      acr_valid_o <= 1'b1;
      acr_cts_o   <= cts;
      acr_n_o     <= n;
      @(posedge clk_i);
      acr_valid_o <= 1'b0;
      acr_cts_o   <= ~cts;
      acr_n_o     <= ~n;
   endtask : send_acr

   task automatic send_avi(input logic [31:0] f);
      @(posedge clk_i);
      avi_valid_o  <= 1'b1;
      avi_fields_o <= f;
      @(posedge clk_i);
      avi_valid_o  <= 1'b0;
      avi_fields_o <= ~f;
   endtask : send_avi
endmodule : link_source_model

// ---- bench/tb_avi_regen_status.sv ----
// Testbench for the clock regeneration and AVI status bank
module tb_avi_regen_status;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc   = 1'b0;
   logic        stb   = 1'b0;
   logic        we    = 1'b0;
   logic [9:0]  adr   = 10'h000;
   logic [31:0] wdat  = 32'h00000000;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic        acr_v;
   logic        avi_v;
   logic [19:0] cts;
   logic [19:0] n;
   logic [31:0] f;
   logic [31:0] q;
   logic [1:0]  lo;
   logic [1:0]  t;
   logic [1:0]  t2;
   logic [7:0]  ver;
   logic        avi_frz;
   logic        acr_frz;
   int          fail_count = 0;
   int          samples_checked = 0;

   always #2 clk_i = ~clk_i;

   link_source_model u_link_source_model (.clk_i(clk_i), .acr_valid_o(acr_v),
      .acr_cts_o(cts), .acr_n_o(n), .avi_valid_o(avi_v), .avi_fields_o(f));

   avi_regen_status u_avi_regen_status (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .acr_valid_i(acr_v), .acr_cts_i(cts),
      .acr_n_i(n), .avi_valid_i(avi_v), .avi_version_i(f[31:24]),
      .avi_colour_format_i(f[23:22]), .avi_format_present_i(f[21]), .avi_bar_info_i(f[20:19]),
      .avi_scan_info_i(f[18:17]), .avi_colorimetry_i(f[16:15]),
      .avi_picture_aspect_i(f[14:13]), .avi_active_aspect_i(f[12:9]),
      .nonuniform_scaling_field_i(f[8:7]), .avi_video_code_i(f[6:0]),
      .avi_frozen_o(avi_frz), .acr_frozen_o(acr_frz));

   task automatic end_of_test();
      $display("comparisons %0d, mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : end_of_test

   task automatic check(input logic [31:0] got, input logic [31:0] want);
      samples_checked++;
      if (got !== want)
      begin
         fail_count++;
         $display("wrong value at %0t: read %h, expected %h", $time, got, want);
      end
   endtask : check

   // Request held until the edge that sees ack, then released
   task automatic wb_xfer(input logic w, input logic [7:0] idx, input logic [31:0] d);
      @(posedge clk_i);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= {idx, 2'b00};
      wdat <= d;
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1)
         @(posedge clk_i);
      q = wb_dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
   endtask : wb_xfer

   task automatic rd_chk(input logic [7:0] idx, input logic [7:0] e);
      wb_xfer(1'b0, idx, 32'h00000000);
      check(q, {24'h000000, e});
   endtask : rd_chk

   initial
   begin
      #20000;
      fail_count++;
      end_of_test();
   end

   initial
   begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = 8'h7b; i <= 8'h84; i++)
         rd_chk(i[7:0], 8'h00);
      u_link_source_model.send_acr(20'habcde, 20'h12345);
      rd_chk(8'h7b, 8'hab);
      rd_chk(8'h7c, 8'hcd);
      rd_chk(8'h7d, 8'he1);
      rd_chk(8'h7e, 8'h23);
      rd_chk(8'h7f, 8'h45);
      // All four codes of bar and scaling, and three of colour format, scan, colorimetry and picture aspect, across four frames
      for (int i = 0; i < 4; i++)
      begin
         lo  = i[1:0];
         t   = 2'(i % 3);
         t2  = 2'((i + 1) % 3);
         ver = 8'hf0 | {6'h00, lo};
         u_link_source_model.send_avi({ver, t, lo[0], lo, t, t, t2, 4'h8 + {2'b00, lo}, lo,
            7'h7c + {5'h00, lo}});
         rd_chk(8'h80, ver);
         rd_chk(8'h81, {1'b0, t, lo[0], lo, t});
         rd_chk(8'h82, {t, t2, 4'h8 + {2'b00, lo}});
         rd_chk(8'h83, {6'h00, lo});
         rd_chk(8'h84, {1'b0, 7'h7c + {5'h00, lo}});
      end
      wb_xfer(1'b1, 8'h80, 32'h000000ff);
      rd_chk(8'h80, 8'hf3);
      wb_xfer(1'b1, 8'h7b, 32'h00000000);
      rd_chk(8'h7b, 8'hab);
      rd_chk(8'h10, 8'h00);
      u_link_source_model.send_acr(20'h0000f, 20'hf0000);
      rd_chk(8'h7d, 8'hff);
      rd_chk(8'h7b, 8'h00);
      // Frozen: packets dropped, flagged as missed, not counted
      wb_xfer(1'b1, 8'hf0, 32'h00000003);
      rd_chk(8'hf0, 8'h03);
      check({30'h0, acr_frz, avi_frz}, 32'h00000003);
      u_link_source_model.send_acr(20'h11111, 20'h22222);
      u_link_source_model.send_avi(32'h01234567);
      rd_chk(8'h7b, 8'h00);
      rd_chk(8'h80, 8'hf3);
      rd_chk(8'hf1, 8'h0f);
      wb_xfer(1'b0, 8'hf2, 32'h00000000);
      check(q, 32'h00000204);
      wb_xfer(1'b1, 8'hf1, 32'h00000003);
      rd_chk(8'hf1, 8'h0c);
      wb_xfer(1'b1, 8'hf0, 32'h00000000);
      rd_chk(8'hf0, 8'h00);
      check({30'h0, acr_frz, avi_frz}, 32'h00000000);
      u_link_source_model.send_acr(20'h11111, 20'h22222);
      rd_chk(8'h7b, 8'h11);
      end_of_test();
   end
endmodule : tb_avi_regen_status
